// file: hdl/lpc_cmd_timing.sv
// device-side command path: latency timing on the link clock, events to the core clock
`timescale 1ns/1ps

module lpc_cmd_timing
	import lpc_pkg::*;
#(
	parameter int DEPTH = PIPE_DEPTH
) (
	input  wire logic     CORE_CLK,
	input  wire logic     RST,
	input  wire lpc_cfg_t CFG,
	input  wire logic     LINK_CK,
	input  wire lpc_cmd_t LINK_CMD,
	output logic          CMD_TAKEN,
	output logic          RD_DATA_START,
	output logic          WR_DATA_START,
	output logic          RD_SEEN,
	output logic          WR_SEEN
);

	if (DEPTH < 16) begin : g_depth_check
		$error("DEPTH must cover the longest latency of 16 cycles");
	end

	// ---------------- core domain ----------------
	lpc_cfg_t cfg_core;
	logic [2:0] rd_tog_sync;
	logic [2:0] wr_tog_sync;
	// toggles are launched in the link domain below
	logic rd_tog;
	logic wr_tog;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cfg_core    <= CFG_RESET;
			rd_tog_sync <= 3'h0;
			wr_tog_sync <= 3'h0;
			RD_SEEN     <= 1'b0;
			WR_SEEN     <= 1'b0;
		end else begin
			cfg_core    <= CFG;
			rd_tog_sync <= {rd_tog_sync[1:0], rd_tog};
			wr_tog_sync <= {wr_tog_sync[1:0], wr_tog};
			RD_SEEN     <= rd_tog_sync[2] ^ rd_tog_sync[1];
			WR_SEEN     <= wr_tog_sync[2] ^ wr_tog_sync[1];
		end
	end

	// ---------------- link domain ----------------
	logic [1:0] rst_link_sync;
	wire        rst_link = rst_link_sync[1];

	// reset leaves the link domain only on its own clock edge
	always_ff @(posedge LINK_CK or posedge RST) begin
		if (RST) begin
			rst_link_sync <= 2'h3;
		end else begin
			rst_link_sync <= {rst_link_sync[0], 1'b0};
		end
	end

	lpc_cfg_t cfg_meta;
	lpc_cfg_t cfg_link;
	logic [CMD_PATH_DISABLE_DELAY-1:0] cke_hist;
	logic [DEPTH-1:0] rd_pipe;
	logic [DEPTH-1:0] wr_pipe;

	// config is expected to stay put while commands are in flight
	wire lpc_lat_t rl     = read_lat(cfg_link.rate);
	wire lpc_lat_t wl     = write_lat(cfg_link.rate, cfg_link.wl_b);
	wire [3:0]     rl_tap = 4'(rl - 5'h01);
	wire [3:0]     wl_tap = 4'(wl - 5'h01);

	wire path_open = LINK_CMD.cke | (|cke_hist);
	wire cmd_ok    = path_open & ~LINK_CMD.cs_n;
	wire rd_acc    = cmd_ok & (LINK_CMD.op == OP_READ);
	wire wr_acc    = cmd_ok & (LINK_CMD.op == OP_WRITE);

	always_ff @(posedge LINK_CK or posedge rst_link) begin
		if (rst_link) begin
			cfg_meta      <= CFG_RESET;
			cfg_link      <= CFG_RESET;
			cke_hist      <= '0;
			rd_pipe       <= '0;
			wr_pipe       <= '0;
			rd_tog        <= 1'b0;
			wr_tog        <= 1'b0;
			CMD_TAKEN     <= 1'b0;
			RD_DATA_START <= 1'b0;
			WR_DATA_START <= 1'b0;
		end else begin
			cfg_meta      <= cfg_core;
			cfg_link      <= cfg_meta;
			cke_hist      <= {cke_hist[CMD_PATH_DISABLE_DELAY-2:0], LINK_CMD.cke};
			rd_pipe       <= {rd_pipe[DEPTH-2:0], rd_acc};
			wr_pipe       <= {wr_pipe[DEPTH-2:0], wr_acc};
			rd_tog        <= rd_tog ^ rd_acc;
			wr_tog        <= wr_tog ^ wr_acc;
			CMD_TAKEN     <= cmd_ok;
			RD_DATA_START <= rd_pipe[rl_tap];
			WR_DATA_START <= wr_pipe[wl_tap];
		end
	end

	// ---------------- checks ----------------
	sequence s_read_at(logic [1:0] r);
		rd_acc && cfg_link.rate == r;
	endsequence

	sequence s_write_at(logic [1:0] r, logic b);
		wr_acc && cfg_link.rate == r && cfg_link.wl_b == b;
	endsequence

	a_read_lat_1600: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_read_at(2'h1) |-> ##13 RD_DATA_START)
		else $error("read data start missed at latency 12");

	a_read_lat_2133: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_read_at(2'h3) |-> ##17 RD_DATA_START)
		else $error("read data start missed at latency 16");

	a_read_not_early: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_read_at(2'h2) ##1 (!rd_acc)[*8] |-> ##5 !RD_DATA_START)
		else $error("read data start came before latency 14");

	a_write_a_1866: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_write_at(2'h2, 1'b0) |-> ##9 WR_DATA_START)
		else $error("set A write window missed at latency 8");

	a_write_a_1333: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_write_at(2'h0, 1'b0) |-> ##7 WR_DATA_START)
		else $error("set A write window missed at latency 6");

	a_write_b_1600: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_write_at(2'h1, 1'b1) |-> ##10 WR_DATA_START)
		else $error("set B write window missed at latency 9");

	a_write_b_2133: assert property (@(posedge LINK_CK) disable iff (rst_link)
		s_write_at(2'h3, 1'b1) |-> ##14 WR_DATA_START)
		else $error("set B write window missed at latency 13");

	a_cke_grace_open: assert property (@(posedge LINK_CK) disable iff (rst_link)
		$fell(LINK_CMD.cke) && !LINK_CMD.cs_n ##1 !LINK_CMD.cke && !LINK_CMD.cs_n
		|-> CMD_TAKEN ##1 CMD_TAKEN)
		else $error("command refused within two cycles of clock enable low");

	a_cke_path_shut: assert property (@(posedge LINK_CK) disable iff (rst_link)
		(!LINK_CMD.cke)[*3] ##0 !LINK_CMD.cs_n |-> ##1 !CMD_TAKEN)
		else $error("command taken after command path disable delay");

	a_seen_follows: assert property (@(posedge LINK_CK) disable iff (rst_link)
		$changed(rd_tog) |-> ##[1:12] RD_SEEN)
		else $error("read event never reached the core side");

endmodule

// file: hdl/lpc_pkg.sv
// constants, types and latency lookups for the command timing block
package lpc_pkg;

	localparam int LAT_W      = 5;
	localparam int PIPE_DEPTH = 16;

	typedef logic [LAT_W-1:0] lpc_lat_t;

	// read latency per data rate index 0..3 (1333, 1600, 1866, 2133)
	localparam lpc_lat_t RL_R0 = 5'h0A;
	localparam lpc_lat_t RL_R1 = 5'h0C;
	localparam lpc_lat_t RL_R2 = 5'h0E;
	localparam lpc_lat_t RL_R3 = 5'h10;
	// write latency, set A
	localparam lpc_lat_t WLA_R0 = 5'h06;
	localparam lpc_lat_t WLA_R1 = 5'h06;
	localparam lpc_lat_t WLA_R2 = 5'h08;
	localparam lpc_lat_t WLA_R3 = 5'h08;
	// write latency, set B
	localparam lpc_lat_t WLB_R0 = 5'h08;
	localparam lpc_lat_t WLB_R1 = 5'h09;
	localparam lpc_lat_t WLB_R2 = 5'h0B;
	localparam lpc_lat_t WLB_R3 = 5'h0D;

	// cycles the command path stays open after clock enable drops
	localparam int CMD_PATH_DISABLE_DELAY = 2;

	typedef enum logic [1:0] {OP_NOP, OP_READ, OP_WRITE, OP_OTHER} lpc_op_t;

	typedef struct packed {
		logic    cke;
		logic    cs_n;
		lpc_op_t op;
	} lpc_cmd_t;

	typedef struct packed {
		logic [1:0] rate;
		logic       wl_b;
	} lpc_cfg_t;

	localparam lpc_cfg_t CFG_RESET = '{rate: 2'h1, wl_b: 1'b0};

	function automatic lpc_lat_t read_lat(input logic [1:0] rate);
		unique case (rate)
			2'h0: read_lat = RL_R0;
			2'h1: read_lat = RL_R1;
			2'h2: read_lat = RL_R2;
			2'h3: read_lat = RL_R3;
		endcase
	endfunction

	function automatic lpc_lat_t write_lat(input logic [1:0] rate, input logic set_b);
		unique case (rate)
			2'h0: write_lat = set_b ? WLB_R0 : WLA_R0;
			2'h1: write_lat = set_b ? WLB_R1 : WLA_R1;
			2'h2: write_lat = set_b ? WLB_R2 : WLA_R2;
			2'h3: write_lat = set_b ? WLB_R3 : WLA_R3;
		endcase
	endfunction

endpackage

// file: sim/lpc_ctrl_model.sv
// controller-side model driving the link command port
`timescale 1ns/1ps

module lpc_ctrl_model
	import lpc_pkg::*;
(
	input  wire logic LINK_CK,
	output lpc_cmd_t  LINK_CMD
);
	initial LINK_CMD = '{cke: 1'h1, cs_n: 1'h1, op: OP_NOP};

	// one command per call; between commands the op lines flip so a deselect is really tested
	task automatic send(input logic cke, input logic cs_n, input lpc_op_t op);
		@(negedge LINK_CK);
		LINK_CMD = '{cke: cke, cs_n: cs_n, op: op};
		@(negedge LINK_CK);
		LINK_CMD = '{cke: cke, cs_n: 1'h1, op: lpc_op_t'(~op)};
	endtask

	// clock enable can also change with a command through send, grace window left to the bench
	// idle gaps keep all spacing minimums
	// no refresh, training or deep sleep issued
	// whole-cycle levels only, so strobe and pulse widths hold
	task automatic idle(input logic cke, input int n);
		repeat (n) begin
			@(negedge LINK_CK);
			LINK_CMD.cke = cke;
		end
	endtask
endmodule

// file: sim/lpc_cmd_timing_tb.sv
// self-checking bench for the command timing block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s expected %0d seen %0d", nm, e, g); end end

module lpc_cmd_timing_tb
	import lpc_pkg::*;
;
	logic     CORE_CLK = 1'h0;
	logic     LINK_CK  = 1'h0;
	logic     RST      = 1'h1;
	lpc_cfg_t cfg      = CFG_RESET;
	lpc_cmd_t link_cmd;
	logic     cmd_taken, rd_start, wr_start, rd_seen, wr_seen;
	int       n_mismatch = 0, n_compared = 0;
	int       n_rd = 0, n_wr = 0, n_rd_exp = 0, n_wr_exp = 0;
	int       rl[4]  = '{10, 12, 14, 16};
	int       wla[4] = '{6, 6, 8, 8};
	int       wlb[4] = '{8, 9, 11, 13};

	always #12.5 CORE_CLK = ~CORE_CLK;
	// odd start offset keeps the two clocks out of step
	initial begin
		#3.1;
		forever #6 LINK_CK = ~LINK_CK;
	end

	lpc_cmd_timing uut (.CORE_CLK(CORE_CLK), .RST(RST), .CFG(cfg), .LINK_CK(LINK_CK),
		.LINK_CMD(link_cmd), .CMD_TAKEN(cmd_taken), .RD_DATA_START(rd_start),
		.WR_DATA_START(wr_start), .RD_SEEN(rd_seen), .WR_SEEN(wr_seen));
	lpc_ctrl_model ctrl (.LINK_CK(LINK_CK), .LINK_CMD(link_cmd));

	always @(posedge CORE_CLK) begin
		if (rd_seen === 1'h1) n_rd++;
		if (wr_seen === 1'h1) n_wr++;
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// cfg must settle in the link domain before any command
	task automatic set_cfg(input logic [1:0] r, input logic b);
		@(negedge CORE_CLK);
		cfg = '{rate: r, wl_b: b};
		ctrl.idle(1'h1, 12);
	endtask

	// edges from the sampling edge to the data start pulse, then the pulse must drop
	task automatic lat(input lpc_op_t op, input int exp, input string nm);
		int n;
		n = 0;
		ctrl.send(1'h1, 1'h0, op);
		do begin
			@(posedge LINK_CK);
			#1;
			n++;
		end while (((op == OP_READ) ? rd_start : wr_start) !== 1'h1 && n < 40);
		`CHK(nm, exp, n)
		@(posedge LINK_CK);
		#1;
		`CHK("start width", 1'h0, (op == OP_READ) ? rd_start : wr_start)
		if (op == OP_READ) n_rd_exp++;
		else n_wr_exp++;
	endtask

	task automatic t_read_lat();
		for (int r = 0; r < 4; r++) begin
			set_cfg(r[1:0], 1'h0);
			lat(OP_READ, rl[r], "read latency");
		end
		$display("read latency test done");
	endtask

	task automatic t_write_lat();
		for (int b = 0; b < 2; b++)
			for (int r = 0; r < 4; r++) begin
				set_cfg(r[1:0], b[0]);
				lat(OP_WRITE, b ? wlb[r] : wla[r], "write latency");
			end
		$display("write latency test done");
	endtask

	// clock enable low for j edges before the command: only j of 0 and 1 still pass
	task automatic t_cke_grace();
		for (int j = 0; j < 3; j++) begin
			ctrl.idle(1'h1, 20);
			ctrl.idle(1'h0, j);
			ctrl.send(1'h0, 1'h0, OP_READ);
			`CHK("cke grace", (j < 2), cmd_taken)
			if (j < 2) n_rd_exp++;
		end
		ctrl.idle(1'h1, 20);
		ctrl.send(1'h1, 1'h1, OP_WRITE);
		`CHK("deselected", 1'h0, cmd_taken)
		ctrl.idle(1'h1, 20);
		$display("clock enable grace test done");
	endtask

	initial begin
		repeat (4) @(posedge CORE_CLK);
		@(negedge CORE_CLK);
		RST = 1'h0;
		ctrl.idle(1'h1, 10);
		t_read_lat();
		t_write_lat();
		t_cke_grace();
		repeat (10) @(negedge CORE_CLK);
		`CHK("read events", n_rd_exp, n_rd)
		`CHK("write events", n_wr_exp, n_wr)
		tally_and_finish();
	end

	// whole run needs about 5.4 us
	initial begin
		#50000;
		n_mismatch++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule
